// ==== hdl/emac_front_pkg.sv ====
// Shared constants and carriers for the MAC front end
package emac_front_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] MAC_SPACE_BIT = 12'h0100;
   localparam logic [11:0] CTL_OFS = 12'h0000;
   localparam logic [11:0] CAP_OFS = 12'h0004;
   localparam logic [11:0] NCFG_OFS = 12'h0100;
   localparam logic [11:0] DMA_OFS = 12'h0104;
   localparam logic [11:0] DBASE_OFS = 12'h0108;
   localparam logic [11:0] DCNT_OFS = 12'h010C;
   localparam logic [11:0] STAT_OFS = 12'h0110;
   // ------------------------------------------------------------
   // Field positions and values
   // ------------------------------------------------------------
   localparam int NCFG_SPEED = 0;
   localparam int NCFG_PADCRC = 1;
   localparam int NCFG_DMA_EN = 2;
   localparam int NCFG_GIG = 10;
   localparam int STAT_ERR = 16;
   localparam logic [1:0] IF_MII = 2'h0;
   localparam logic [1:0] IF_GMII = 2'h1;
   localparam logic [1:0] IF_RGMII = 2'h2;
   localparam logic [1:0] IF_RMII = 2'h3;
   localparam logic [31:0] NCFG_RST = 32'h0000_0000;
   localparam logic [31:0] DMA_RST = 32'h0000_0000;
   localparam logic [10:0] MAX_FRAME = 11'h600;
   localparam logic [1:0] NUM_QUEUES = 2'h3;
   localparam logic [7:0] LONG_BURST = 8'h03;
   localparam int MAX_OUT = 2;
   localparam logic [2:0] BEAT_SIZE = 3'h3;
   localparam logic [1:0] BURST_INCR = 2'h1;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} speed_t;
   typedef struct packed {
      logic [31:0] addr;
      logic [7:0] len;
      logic [2:0] size;
      logic [1:0] burst;
   } axi_addr_t;
   typedef struct packed {
      logic [31:0] addr;
      logic [63:0] data;
   } wb_entry_t;
   typedef struct packed {
      logic [1:0] iface;
      speed_t speed;
      logic nibble;
      logic bad;
   } phy_mode_t;
endpackage

// ==== hdl/emac_front.sv ====
// MAC front end: register slave, descriptor mover, PHY mode select
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Parameterised FIFO
// ------------------------------------------------------------
module emac_fifo #(
   parameter int W = 64,
   parameter int D = 16
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Fill side
   input wire logic i_valid,
   input wire logic [W-1:0] i_data,
   output logic o_ready,
   // Drain side
   output logic o_valid,
   output logic [W-1:0] o_data,
   input wire logic i_ready,
   // Fill level
   output logic [$clog2(D+1)-1:0] o_count
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_q, rp_q;
   logic [$clog2(D+1)-1:0] cnt_q;
   logic push, pop;
   // Honest flags straight from the fill level
   assign o_ready = (cnt_q != D[$clog2(D+1)-1:0]);
   assign o_valid = (cnt_q != '0);
   assign o_data = mem[rp_q];
   assign o_count = cnt_q;
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;
   // Storage has no reset
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wp_q] <= i_data;
      end
   end
   // Pointers and level
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= AW'(wp_q + 1'b1);
         end
         if (pop) begin
            rp_q <= AW'(rp_q + 1'b1);
         end
         cnt_q <= cnt_q + push - pop;
      end
   end
endmodule

// Contract
// - The memory master keeps separate read and write data channels with own address channels.
// - No more than two reads and two writes are outstanding on the memory master at once.
// - Descriptors are fetched ahead into a local FIFO so the mover waits on a fetch only while that FIFO is empty.
// - Descriptor write-backs are queued locally so slow completion does not block the mover.
// - A write-back counts as done only when its write response has come back.
// - Fetch bursts are single beats or four 64-bit beats, 8 or 32 bytes per request.
// - Each access to a listed offset is decoded to the wrapper control space or the MAC registers; other addresses get SLVERR.
// - Wrapper control registers drive MAC configuration inputs, the interface select among them.
// - Interface select 0 is MII, 1 GMII, 2 RGMII, 3 RMII.
// - Bit 10 picks 1000 Mbps, else bit 0 picks 100 or 10; gigabit only on GMII and RGMII.
// - RGMII moves four bits per interface clock at every speed.
// - A build parameter fixes RGMII or the GMII/MII family, never both.
// - Frames are at most 1536 bytes long.
// - Transmit pads short frames and appends a CRC.
// - Three priority queues exist in each direction.
module emac_front #(
   parameter bit RGMII_BUILD = 1'b1,
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Register slave, AXI4-Lite
   input wire logic [11:0] i_s_awaddr,
   input wire logic i_s_awvalid,
   output logic o_s_awready,
   input wire logic [31:0] i_s_wdata,
   input wire logic [3:0] i_s_wstrb,
   input wire logic i_s_wvalid,
   output logic o_s_wready,
   output logic [1:0] o_s_bresp,
   output logic o_s_bvalid,
   input wire logic i_s_bready,
   input wire logic [11:0] i_s_araddr,
   input wire logic i_s_arvalid,
   output logic o_s_arready,
   output logic [31:0] o_s_rdata,
   output logic [1:0] o_s_rresp,
   output logic o_s_rvalid,
   input wire logic i_s_rready,
   // Memory master, AXI4
   output emac_front_pkg::axi_addr_t o_m_ar,
   output logic o_m_arvalid,
   input wire logic i_m_arready,
   input wire logic [63:0] i_m_rdata,
   input wire logic i_m_rvalid,
   output logic o_m_rready,
   output emac_front_pkg::axi_addr_t o_m_aw,
   output logic o_m_awvalid,
   input wire logic i_m_awready,
   output logic [63:0] o_m_wdata,
   output logic [7:0] o_m_wstrb,
   output logic o_m_wlast,
   output logic o_m_wvalid,
   input wire logic i_m_wready,
   input wire logic [1:0] i_m_bresp,
   input wire logic i_m_bvalid,
   output logic o_m_bready,
   // Data mover side
   output logic [63:0] o_desc_data,
   output logic o_desc_valid,
   input wire logic i_desc_ready,
   input wire emac_front_pkg::wb_entry_t i_wb,
   input wire logic i_wb_valid,
   output logic o_wb_ready,
   // MAC configuration
   output emac_front_pkg::phy_mode_t o_phy_mode,
   output logic o_pad_crc_en,
   output logic [10:0] o_max_frame
);
   localparam int CW = $clog2(FIFO_DEPTH + 1);
   localparam int BMAX = 16;
   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [1:0] if_sel_q;
   logic [31:0] ncfg_q, dma_q, dbase_q, dcnt_q;
   logic [15:0] wb_done_q;
   logic err_q;
   logic [11:0] awa_q;
   logic aw_got_q, w_got_q;
   logic [31:0] wd_q;
   logic bvalid_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic wr_go, b_ev;

   // Decode: only the seven listed offsets are mapped, by full address
   function automatic logic mapped(input logic [11:0] a);
      unique case (a)
         emac_front_pkg::CTL_OFS, emac_front_pkg::CAP_OFS,
         emac_front_pkg::NCFG_OFS, emac_front_pkg::DMA_OFS,
         emac_front_pkg::DBASE_OFS, emac_front_pkg::DCNT_OFS,
         emac_front_pkg::STAT_OFS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   assign o_s_awready = !aw_got_q && !bvalid_q;
   assign o_s_wready = !w_got_q && !bvalid_q;
   assign o_s_arready = !rvalid_q;
   assign o_s_bvalid = bvalid_q;
   assign o_s_bresp = bresp_q;
   assign o_s_rvalid = rvalid_q;
   assign o_s_rresp = rresp_q;
   assign o_s_rdata = rdata_q;
   assign wr_go = aw_got_q && w_got_q && !bvalid_q;
   assign b_ev = i_m_bvalid && o_m_bready;

   // Address and data latch in either order
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awa_q <= '0;
         wd_q <= '0;
      end else begin
         if (i_s_awvalid && o_s_awready) begin
            aw_got_q <= 1'b1;
            awa_q <= i_s_awaddr;
         end
         if (i_s_wvalid && o_s_wready) begin
            w_got_q <= 1'b1;
            wd_q <= i_s_wdata;
         end
         if (wr_go) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
         end
      end
   end

   // Write response once both halves are in
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         bvalid_q <= 1'b0;
         bresp_q <= emac_front_pkg::RESP_OK;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= mapped(awa_q) ? emac_front_pkg::RESP_OK : emac_front_pkg::RESP_SLVERR;
      end else if (i_s_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Register writes; byte strobes ignored, whole word stored for NCFG, DMA and DBASE here, CTL keeps bits 1:0
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         if_sel_q <= emac_front_pkg::IF_MII;
         ncfg_q <= emac_front_pkg::NCFG_RST;
         dma_q <= emac_front_pkg::DMA_RST;
         dbase_q <= '0;
      end else if (wr_go) begin
         unique case (awa_q)
            emac_front_pkg::CTL_OFS: if_sel_q <= wd_q[1:0];
            emac_front_pkg::NCFG_OFS: ncfg_q <= wd_q;
            emac_front_pkg::DMA_OFS: dma_q <= wd_q;
            emac_front_pkg::DBASE_OFS: dbase_q <= wd_q;
            default: ;
         endcase
      end
   end

   // Read data path
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= emac_front_pkg::RESP_OK;
      end else if (i_s_arvalid && o_s_arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= mapped(i_s_araddr) ? emac_front_pkg::RESP_OK : emac_front_pkg::RESP_SLVERR;
         unique case (i_s_araddr)
            emac_front_pkg::CTL_OFS: rdata_q <= {30'h0, if_sel_q};
            emac_front_pkg::CAP_OFS: rdata_q <= {15'h0, RGMII_BUILD, 3'h0,
                                     emac_front_pkg::NUM_QUEUES, emac_front_pkg::MAX_FRAME};
            emac_front_pkg::NCFG_OFS: rdata_q <= ncfg_q;
            emac_front_pkg::DMA_OFS: rdata_q <= dma_q;
            emac_front_pkg::DBASE_OFS: rdata_q <= dbase_q;
            emac_front_pkg::DCNT_OFS: rdata_q <= dcnt_q;
            emac_front_pkg::STAT_OFS: rdata_q <= {15'h0, err_q, wb_done_q};
            default: rdata_q <= '0;
         endcase
      end else if (i_s_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // PHY mode selection
   // ------------------------------------------------------------
   function automatic emac_front_pkg::phy_mode_t decode_mode(input logic [1:0] s,
                                                            input logic [31:0] c);
      emac_front_pkg::phy_mode_t m;
      m.iface = s;
      m.speed = c[emac_front_pkg::NCFG_GIG] ? emac_front_pkg::SPD_1000 :
                c[emac_front_pkg::NCFG_SPEED] ? emac_front_pkg::SPD_100 :
                emac_front_pkg::SPD_10;
      m.nibble = (s == emac_front_pkg::IF_RGMII);
      // Only one family is built; the other family's select values are flagged
      m.bad = (RGMII_BUILD ? (s == emac_front_pkg::IF_MII || s == emac_front_pkg::IF_GMII)
                           : (s == emac_front_pkg::IF_RGMII)) ||
              (c[emac_front_pkg::NCFG_GIG] && (s == emac_front_pkg::IF_MII ||
               s == emac_front_pkg::IF_RMII)) ||
              (s == emac_front_pkg::IF_GMII && !c[emac_front_pkg::NCFG_GIG]);
      return m;
   endfunction

   // Registered config outputs; the select is expected to settle first
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_phy_mode <= decode_mode(emac_front_pkg::IF_MII, emac_front_pkg::NCFG_RST);
         o_pad_crc_en <= 1'b0;
         o_max_frame <= emac_front_pkg::MAX_FRAME;
      end else begin
         o_phy_mode <= decode_mode(if_sel_q, ncfg_q);
         o_pad_crc_en <= ncfg_q[emac_front_pkg::NCFG_PADCRC];
         o_max_frame <= emac_front_pkg::MAX_FRAME;
      end
   end

   // ------------------------------------------------------------
   // Descriptor prefetch (read channel)
   // ------------------------------------------------------------
   logic [1:0] rd_out_q;
   logic [CW-1:0] rsv_q;
   logic [CW-1:0] pf_cnt;
   logic pf_ready, ar_hs, r_hs, dma_en;
   logic [7:0] blen;
   logic [31:0] next_addr_q;
   logic ar_can;
   logic [7:0] beat_q;
   logic [7:0] len_q [2];
   logic lp_q, rlast_q;
   assign dma_en = ncfg_q[emac_front_pkg::NCFG_DMA_EN];
   // Long bursts only while enough words remain
   assign blen = (dma_q[0] && dcnt_q >= 32'h0000_0004) ? emac_front_pkg::LONG_BURST : 8'h00;
   // Room is reserved at issue so returning beats never stall
   assign ar_can = dma_en && dcnt_q != '0 && rd_out_q < 2'(emac_front_pkg::MAX_OUT) &&
                   (32'(pf_cnt) + 32'(rsv_q) + 32'(blen) + 32'h1) <= 32'(FIFO_DEPTH);
   assign ar_hs = o_m_arvalid && i_m_arready;
   assign r_hs = i_m_rvalid && o_m_rready;
   assign o_m_rready = pf_ready;

   // Address issue; valid held until taken
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_m_arvalid <= 1'b0;
         o_m_ar <= '0;
         next_addr_q <= '0;
         dcnt_q <= '0;
      end else begin
         if (ar_hs) begin
            o_m_arvalid <= 1'b0;
         end
         if (wr_go && awa_q == emac_front_pkg::DCNT_OFS) begin
            dcnt_q <= wd_q;
            next_addr_q <= dbase_q;
         end else if (!o_m_arvalid && ar_can) begin
            o_m_arvalid <= 1'b1;
            o_m_ar <= '{next_addr_q, blen, emac_front_pkg::BEAT_SIZE,
                        emac_front_pkg::BURST_INCR};
            next_addr_q <= next_addr_q + {21'h0, blen + 8'h1, 3'h0};
            dcnt_q <= dcnt_q - {24'h0, blen} - 32'h1;
         end
      end
   end

   // Outstanding bursts and reserved beats
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         rd_out_q <= '0;
         rsv_q <= '0;
      end else begin
         if (!o_m_arvalid && ar_can && !(wr_go && awa_q == emac_front_pkg::DCNT_OFS)) begin
            rd_out_q <= rd_out_q + 2'h1 - 2'(r_hs && rlast_q);
            rsv_q <= rsv_q + CW'(blen) + CW'(1) - CW'(r_hs);
         end else begin
            rd_out_q <= rd_out_q - 2'(r_hs && rlast_q);
            rsv_q <= rsv_q - CW'(r_hs);
         end
      end
   end

   // Beat counter to find each burst's last beat
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         beat_q <= '0;
         lp_q <= 1'b0;
         len_q[0] <= '0;
         len_q[1] <= '0;
      end else begin
         if (!o_m_arvalid && ar_can && !(wr_go && awa_q == emac_front_pkg::DCNT_OFS)) begin
            len_q[(rd_out_q == 2'h0) ? lp_q : !lp_q] <= blen;
         end
         if (r_hs) begin
            beat_q <= rlast_q ? 8'h00 : beat_q + 8'h01;
            lp_q <= rlast_q ? !lp_q : lp_q;
         end
      end
   end
   assign rlast_q = (beat_q == len_q[lp_q]);

   emac_fifo #(.W(64), .D(FIFO_DEPTH)) u_prefetch (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_valid(i_m_rvalid),
      .i_data(i_m_rdata),
      .o_ready(pf_ready),
      .o_valid(o_desc_valid),
      .o_data(o_desc_data),
      .i_ready(i_desc_ready),
      .o_count(pf_cnt)
   );

   // ------------------------------------------------------------
   // Write-back queue (write channel)
   // ------------------------------------------------------------
   emac_front_pkg::wb_entry_t wb_head;
   logic wb_valid, aw_done_q, w_done_q, wb_pop;
   logic [1:0] wr_out_q;
   emac_fifo #(.W($bits(emac_front_pkg::wb_entry_t)), .D(FIFO_DEPTH)) u_wbq (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_valid(i_wb_valid),
      .i_data(i_wb),
      .o_ready(o_wb_ready),
      .o_valid(wb_valid),
      .o_data(wb_head),
      .i_ready(wb_pop),
      .o_count()
   );
   assign o_m_aw = '{wb_head.addr, 8'h00, emac_front_pkg::BEAT_SIZE,
                     emac_front_pkg::BURST_INCR};
   assign o_m_wdata = wb_head.data;
   assign o_m_wstrb = 8'hFF;
   assign o_m_wlast = 1'b1;
   // Entry leaves the queue once both channels have taken it
   assign o_m_awvalid = wb_valid && !aw_done_q && wr_out_q < 2'(emac_front_pkg::MAX_OUT);
   assign o_m_wvalid = wb_valid && !w_done_q && wr_out_q < 2'(emac_front_pkg::MAX_OUT);
   assign wb_pop = wb_valid && (aw_done_q || i_m_awready && o_m_awvalid) &&
                   (w_done_q || i_m_wready && o_m_wvalid);
   assign o_m_bready = 1'b1;

   // Channel progress per entry
   always_ff @(posedge i_clk) begin
      if (!i_rstn || wb_pop) begin
         aw_done_q <= 1'b0;
         w_done_q <= 1'b0;
      end else begin
         aw_done_q <= aw_done_q || (o_m_awvalid && i_m_awready);
         w_done_q <= w_done_q || (o_m_wvalid && i_m_wready);
      end
   end

   // Completion only on response; error set beats a clear
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         wr_out_q <= '0;
         wb_done_q <= '0;
         err_q <= 1'b0;
      end else begin
         wr_out_q <= wr_out_q + 2'(wb_pop) - 2'(b_ev);
         if (b_ev) begin
            wb_done_q <= wb_done_q + 16'h0001;
         end
         if (b_ev && i_m_bresp != emac_front_pkg::RESP_OK) begin
            err_q <= 1'b1;
         end else if (wr_go && awa_q == emac_front_pkg::STAT_OFS &&
                      wd_q[emac_front_pkg::STAT_ERR]) begin
            err_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   localparam int RSP_MAX = 1;
   sequence s_both_in;
      aw_got_q && w_got_q && !bvalid_q;
   endsequence
   a_rd_limit: assert property (@(posedge i_clk) disable iff (!i_rstn)
      rd_out_q <= 2'h2) else $error("too many reads outstanding");
   a_wr_limit: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_out_q <= 2'h2) else $error("too many writes outstanding");
   a_ar_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_m_arvalid && !i_m_arready |=> o_m_arvalid && $stable(o_m_ar))
      else $error("read address dropped early");
   a_burst_len: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_m_arvalid |-> o_m_ar.len == 8'h00 || o_m_ar.len == 8'h03)
      else $error("illegal burst length");
   a_done_resp: assert property (@(posedge i_clk) disable iff (!i_rstn)
      $changed(wb_done_q) |-> $past(b_ev)) else $error("done without response");
   a_bresp_time: assert property (@(posedge i_clk) disable iff (!i_rstn)
      s_both_in |-> ##[1:RSP_MAX] o_s_bvalid) else $error("write response late");
   a_rgmii_nib: assert property (@(posedge i_clk) disable iff (!i_rstn)
      ##1 o_phy_mode.nibble == ($past(if_sel_q) == emac_front_pkg::IF_RGMII))
      else $error("nibble mode wrong");
   a_gig_speed: assert property (@(posedge i_clk) disable iff (!i_rstn)
      $past(ncfg_q[emac_front_pkg::NCFG_GIG]) |-> o_phy_mode.speed == emac_front_pkg::SPD_1000)
      else $error("gigabit not selected");
   a_no_overfill: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_m_rvalid |-> pf_ready) else $error("prefetch overfilled");
endmodule

`default_nettype wire

// ==== test/mem_model.sv ====
// Memory slave model facing the front end's AXI4 master
`timescale 1ns/100ps
`default_nettype none
module mem_model (
   // Clock, reset, error knob
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_err,
   // Read side
   input wire emac_front_pkg::axi_addr_t i_ar,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [63:0] o_rdata,
   output logic o_rvalid,
   input wire logic i_rready,
   // Write side
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // Bursts in flight
   output int o_rd_out,
   output int o_wr_out
);
   emac_front_pkg::axi_addr_t rq_q[$];
   int beat_q, na_q, nw_q;
   // Random stalls; released data flips so stale beats never look valid
   always @(posedge i_clk) begin
      o_arready <= 1'($urandom_range(1, 0));
      o_awready <= 1'($urandom_range(1, 0));
      o_wready <= 1'($urandom_range(1, 0));
      if (!i_rstn) begin
         rq_q.delete();
         beat_q = 0;
         na_q = 0;
         nw_q = 0;
         o_rvalid <= 1'b0;
         o_bvalid <= 1'b0;
         o_rd_out <= 0;
         o_wr_out <= 0;
      end else begin
         if (i_arvalid && o_arready) rq_q.push_back(i_ar);
         if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_rdata <= ~o_rdata;
            beat_q++;
            if (beat_q > rq_q[0].len) begin
               beat_q = 0;
               void'(rq_q.pop_front());
            end
         end else if (!o_rvalid && rq_q.size() > 0 && $urandom_range(1, 0) == 1) begin
            o_rvalid <= 1'b1;
            o_rdata <= {32'h0000_0000, rq_q[0].addr + 32'(beat_q * 8)};
         end
         o_rd_out <= rq_q.size();
         if (i_awvalid && o_awready) na_q++;
         if (i_wvalid && o_wready) nw_q++;
         o_wr_out <= o_wr_out + int'(i_awvalid && o_awready) - int'(o_bvalid && i_bready);
         if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
            o_bresp <= ~o_bresp;
         end else if (!o_bvalid && na_q > 0 && nw_q > 0) begin
            na_q--;
            nw_q--;
            o_bvalid <= 1'b1;
            o_bresp <= i_err ? emac_front_pkg::RESP_SLVERR : emac_front_pkg::RESP_OK;
         end
      end
   end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the MAC front end
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam logic [3:0] MODES [8] = '{4'h0, 4'h1, 4'h6, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD};
   logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, wbv = 1'b0;
   logic desc_rdy = 1'b0, err = 1'b0, mwl, mbrdy;
   logic [7:0] mws;
   logic [11:0] awa = 12'h000, ara = 12'h000;
   logic [31:0] wd = 32'h0000_0000, d, nc;
   logic [1:0] r;
   logic [3:0] m;
   emac_front_pkg::wb_entry_t wb = '0;
   logic awr, wr_r, bv, arr, rv, marv, mrr, mawv, mwv, descv, wbr, pad, mar, mrv, maw, mw, mbv;
   logic [1:0] br, rr, mbr;
   logic [31:0] rd_d;
   logic [63:0] mwd, descd, mrd;
   logic [10:0] maxf;
   emac_front_pkg::axi_addr_t m_ar, m_aw;
   emac_front_pkg::phy_mode_t mode;
   int rd_out, wr_out, err_count = 0, check_count = 0;
   logic [63:0] got[$], wdq[$];
   logic [31:0] wq[$];
   emac_front DUT (.i_clk(clk), .i_rstn(rstn), .i_s_awaddr(awa), .i_s_awvalid(awv),
      .o_s_awready(awr), .i_s_wdata(wd), .i_s_wstrb(4'hF), .i_s_wvalid(wv), .o_s_wready(wr_r),
      .o_s_bresp(br), .o_s_bvalid(bv), .i_s_bready(1'b1), .i_s_araddr(ara), .i_s_arvalid(arv),
      .o_s_arready(arr), .o_s_rdata(rd_d), .o_s_rresp(rr), .o_s_rvalid(rv), .i_s_rready(1'b1),
      .o_m_ar(m_ar), .o_m_arvalid(marv), .i_m_arready(mar), .i_m_rdata(mrd), .i_m_rvalid(mrv),
      .o_m_rready(mrr), .o_m_aw(m_aw), .o_m_awvalid(mawv), .i_m_awready(maw), .o_m_wdata(mwd),
      .o_m_wstrb(mws), .o_m_wlast(mwl), .o_m_wvalid(mwv), .i_m_wready(mw), .i_m_bresp(mbr),
      .i_m_bvalid(mbv), .o_m_bready(mbrdy), .o_desc_data(descd), .o_desc_valid(descv),
      .i_desc_ready(desc_rdy), .i_wb(wb), .i_wb_valid(wbv), .o_wb_ready(wbr),
      .o_phy_mode(mode), .o_pad_crc_en(pad), .o_max_frame(maxf));
   mem_model mem (.i_clk(clk), .i_rstn(rstn), .i_err(err), .i_ar(m_ar), .i_arvalid(marv),
      .o_arready(mar), .o_rdata(mrd), .o_rvalid(mrv), .i_rready(mrr), .i_awvalid(mawv),
      .o_awready(maw), .i_wvalid(mwv), .o_wready(mw), .o_bresp(mbr), .o_bvalid(mbv),
      .i_bready(mbrdy), .o_rd_out(rd_out), .o_wr_out(wr_out));
   // Clock at 125 MHz
   initial forever #4 clk = ~clk;
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // Both halves offered together, each released once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rsp);
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_r) wv <= 1'b0;
      end while (!bv);
      rsp = br;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
      ara <= a;
      arv <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end while (!rv);
      v = rd_d;
      rsp = rr;
   endtask
   // Valid stays up between pushes; the caller drops it
   task automatic push_wb(input logic [31:0] a);
      logic [63:0] v = {32'($urandom), 32'($urandom)};
      wb <= {a, v};
      wbv <= 1'b1;
      do @(posedge clk); while (!wbr);
      wq.push_back(a);
      wdq.push_back(v);
   endtask
   function automatic logic [1:0] exp_spd(input logic [31:0] n);
      return n[10] ? 2'h2 : (n[0] ? 2'h1 : 2'h0);
   endfunction
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Master-side monitor and random descriptor consumer
   always @(posedge clk) begin
      if (marv && mar) begin
         chk(m_ar.len, m_ar.addr < 32'h0000_1040 ? emac_front_pkg::LONG_BURST : 8'h00);
         chk(m_ar.size, emac_front_pkg::BEAT_SIZE);
         chk(rd_out < emac_front_pkg::MAX_OUT, 1'b1);
      end
      if (mawv && maw) begin
         chk(m_aw.addr, wq.pop_front());
         chk(wr_out < emac_front_pkg::MAX_OUT, 1'b1);
      end
      if (mwv && mw) begin
         chk(mwd, wdq.pop_front());
         chk({mws, mwl}, 9'h1FF);
      end
      if (descv && desc_rdy) got.push_back(descd);
      desc_rdy <= 1'($urandom_range(1, 0));
   end
   initial begin
      #160000;
      err_count++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'h723fddc8));
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk(mode.iface, emac_front_pkg::IF_MII);
      chk(mode.speed, 2'h0);
      chk(mode.bad, 1'b1);
      chk(maxf, emac_front_pkg::MAX_FRAME);
      rd(emac_front_pkg::CAP_OFS, d, r);
      chk(d, 32'h0001_1E00);
      rd(12'h0200, d, r);
      chk({r, d}, {emac_front_pkg::RESP_SLVERR, 32'h0000_0000});
      wr(12'h0204, 32'h0000_0001, r);
      chk(r, emac_front_pkg::RESP_SLVERR);
      $display("Test registers done");
      // Listed modes only, select before network setup
      for (int i = 0; i < 8; i++) begin
         m = MODES[i];
         nc = {21'h0, m[1], 8'h0, 1'($urandom), m[0]};
         wr(emac_front_pkg::CTL_OFS, {30'h0, m[3:2]}, r);
         wr(emac_front_pkg::NCFG_OFS, nc, r);
         rd(emac_front_pkg::CTL_OFS, d, r);
         chk(d[1:0], m[3:2]);
         chk(mode.iface, m[3:2]);
         chk(mode.speed, exp_spd(nc));
         chk(pad, nc[1]);
         chk(mode.nibble, m[3:2] == emac_front_pkg::IF_RGMII);
         if (m[3:2] != emac_front_pkg::IF_RMII) chk(mode.bad, m[3:2] != 2'h2);
      end
      $display("Test modes done");
      wr(emac_front_pkg::DBASE_OFS, 32'h0000_1000, r);
      wr(emac_front_pkg::DMA_OFS, 32'h0000_0001, r);
      wr(emac_front_pkg::DCNT_OFS, 32'h0000_000A, r);
      wr(emac_front_pkg::NCFG_OFS, 32'h0000_0004, r);
      while (got.size() < 10) @(posedge clk);
      for (int i = 0; i < 10; i++) chk(got[i], 64'(32'h0000_1000 + 32'(i * 8)));
      $display("Test prefetch done");
      for (int i = 0; i < 3; i++) push_wb(32'h0000_2000 + 32'(i * 8));
      wbv <= 1'b0;
      do rd(emac_front_pkg::STAT_OFS, d, r); while (d[15:0] != 16'h3);
      chk(d, 32'h0000_0003);
      err <= 1'b1;
      push_wb(32'h0000_3000);
      wbv <= 1'b0;
      do rd(emac_front_pkg::STAT_OFS, d, r); while (d[15:0] != 16'h4);
      chk(d[16], 1'b1);
      wr(emac_front_pkg::STAT_OFS, 32'h0001_0000, r);
      rd(emac_front_pkg::STAT_OFS, d, r);
      chk(d, 32'h0000_0004);
      $display("Test write-back done");
      wrap_up();
   end
endmodule
`default_nettype wire
